// ===== core/cfsup_pkg.sv
/*
 * Shared constants and types for the converter fault and configuration
 * supervisor. Assumes a single 100 MHz controller clock.
 */
package cfsup_pkg;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int FLT_DEGLITCH_NS = 1000;
   // Longest time: round down
   localparam int FLT_DEGLITCH_CYC = FLT_DEGLITCH_NS / CLK_PERIOD_NS;
   // Sync stages plus output register eat into the budget
   localparam int FLT_FILT_CYC = FLT_DEGLITCH_CYC - 4;
   localparam int HICCUP_ON_US = 500;
   localparam int HICCUP_OFF_US = 5000;
   // Least times: round up
   localparam int HICCUP_ON_CYC =
      (HICCUP_ON_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HICCUP_OFF_CYC =
      (HICCUP_OFF_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CFG_SETTLE_CYC = 16;
   localparam int TMR_W = 24;
   localparam int DG_CNT_W = 16;

   // ****************************************************************
   // Strap index fields and current limit stepping
   // ****************************************************************
   localparam int STRAP_W = 4;
   localparam int STRAP_DITHER_BIT = 0;
   localparam int STRAP_HICCUP_BIT = 1;
   localparam int STRAP_CLIMIT_BIT = 2;
   localparam int STRAP_THR15_BIT = 3;
   localparam logic [7:0] CL_LEVEL_MAX = 8'hFF;
   localparam logic [3:0] CL_DIV_RST = 4'h0;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [2:0] {
      ST_OFF = 3'b000,
      ST_READ_CFG = 3'b001,
      ST_SOFTSTART = 3'b010,
      ST_ACTIVE = 3'b011,
      ST_HICCUP_OFF = 3'b100,
      ST_HALT = 3'b101
   } cfsup_state_t;

   typedef struct packed {
      logic dither;
      logic hiccup;
      logic cur_limit;
      logic thr_15;
   } cfsup_cfg_t;

   typedef struct packed {
      logic thermal;
      logic peak_oc;
      logic fb_ov;
      logic vout_ov;
      logic vin_ov;
      logic pg_low;
      logic boot_uv;
   } cfsup_fault_t;

   typedef struct packed {
      logic en_high;
      logic vcc_uv;
      logic ss_done;
      logic light_load;
      logic aux_over_ref;
      logic boot_ov;
      logic forced_pwm_req;
      logic ext_sync;
      logic [STRAP_W-1:0] strap;
   } cfsup_ctrl_t;

   typedef struct packed {
      logic s1;
      logic s2;
      logic out;
      logic [DG_CNT_W-1:0] cnt;
   } cfsup_dg_t;

endpackage

// ===== core/cfsup_deglitch.sv
/*
 * Two-stage synchroniser followed by a stability filter for one pin.
 * Assumes the pin is asynchronous to i_clock.
 */
`timescale 1ns/1ps
`default_nettype none
module cfsup_deglitch #(
   parameter logic [15:0] FILT = 16'h0001
) (
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic i_pin,
   output logic o_level
);
   import cfsup_pkg::*;

   cfsup_dg_t q;
   cfsup_dg_t d;

   // Only s2 looks at s1; the filter reads s2 alone
   always_comb begin
      d = q;
      d.s1 = i_pin;
      d.s2 = q.s1;
      if (q.s2 == q.out) begin
         d.cnt = '0;
      end else if (q.cnt == FILT - 16'h0001) begin
         d.out = q.s2;
         d.cnt = '0;
      end else begin
         d.cnt = q.cnt + 16'h0001;
      end
   end

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign o_level = q.out;

endmodule
`default_nettype wire

// ===== core/cfsup_top.sv
/*
 * Supervisor of a four-switch buck-boost controller: strap and sync
 * sampling, hiccup sequencing, protection responses, fault pin.
 * Assumes analog comparators arrive as asynchronous levels and that
 * the open-drain fault pin is resolved outside.
 */
`timescale 1ns/1ps
`default_nettype none
module cfsup_top #(
   parameter int HICCUP_ON_CYCLES = cfsup_pkg::HICCUP_ON_CYC,
   parameter int HICCUP_OFF_CYCLES = cfsup_pkg::HICCUP_OFF_CYC
) (
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire cfsup_pkg::cfsup_fault_t i_fault,
   input wire cfsup_pkg::cfsup_ctrl_t i_ctrl,
   output logic o_fault_flag_n_o,
   output logic o_fault_flag_n_oe,
   output cfsup_pkg::cfsup_cfg_t o_cfg,
   output logic o_cfg_valid,
   output logic o_dir_positive,
   output cfsup_pkg::cfsup_state_t o_state,
   output logic o_switch_en,
   output logic o_ss_discharge,
   output logic o_float_switch_nodes,
   output logic o_forced_pwm_en,
   output logic o_forward_only,
   output logic o_boot_clamp_sink,
   output logic o_fb_ov_report,
   output logic o_peak_overcurrent_trip,
   output logic [7:0] o_peak_limit_level
);
   import cfsup_pkg::*;

   // ****************************************************************
   // Input conditioning
   // ****************************************************************
   localparam int NF = $bits(cfsup_fault_t);
   localparam int NC = $bits(cfsup_ctrl_t);
   localparam logic [15:0] FLT_FILT = 16'(FLT_FILT_CYC);
   localparam logic [TMR_W-1:0] ON_LAST = TMR_W'(HICCUP_ON_CYCLES - 1);
   localparam logic [TMR_W-1:0] OFF_LAST = TMR_W'(HICCUP_OFF_CYCLES - 1);
   localparam logic [TMR_W-1:0] CFG_LAST = TMR_W'(CFG_SETTLE_CYC - 1);

   logic [NF-1:0] flt_vec;
   logic [NC-1:0] ctl_vec;
   cfsup_fault_t f;
   cfsup_ctrl_t c;

   genvar gi;
   generate
      for (gi = 0; gi < NF; gi++) begin : g_flt
         // Every fault path is filtered before it reaches the pin
         cfsup_deglitch #(.FILT(FLT_FILT)) u_dg (
            .i_clock(i_clock),
            .i_nrst(i_nrst),
            .i_pin(i_fault[gi]),
            .o_level(flt_vec[gi])
         );
      end
      for (gi = 0; gi < NC; gi++) begin : g_ctl
         cfsup_deglitch #(.FILT(16'h0001)) u_sy (
            .i_clock(i_clock),
            .i_nrst(i_nrst),
            .i_pin(i_ctrl[gi]),
            .o_level(ctl_vec[gi])
         );
      end
   endgenerate

   assign f = flt_vec;
   assign c = ctl_vec;

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      cfsup_state_t st;
      cfsup_cfg_t cfg;
      logic cfg_valid;
      logic dir_pos;
      logic sync_seen_hi;
      logic [TMR_W-1:0] tmr;
      logic [7:0] cl_level;
      logic [3:0] cl_div;
      logic fault;
      logic sw_en;
      logic ss_dis;
      logic float_sw;
      logic forced_pwm_en;
      logic fwd_only;
      logic bst_sink;
      logic fb_rep;
      logic pk_flag;
   } cfsup_core_t;

   cfsup_core_t q;
   cfsup_core_t d;
   logic en_lost;
   logic halt_req;
   logic running;
   logic fb_masked;
   logic pg_fault;

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      d = q;
      en_lost = !c.en_high || c.vcc_uv;
      halt_req = f.thermal || f.boot_uv;
      // Guard blind outside regulation and in light load
      fb_masked = f.fb_ov && (q.st == ST_ACTIVE) && !c.light_load;
      pg_fault = f.pg_low && (q.st == ST_ACTIVE);

      case (q.st)
         ST_OFF: begin
            d.tmr = '0;
            d.sync_seen_hi = 1'b0;
            if (!en_lost) begin
               d.st = ST_READ_CFG;
            end
         end
         ST_READ_CFG: begin
            // Sync seen high at any point means level high or a clock
            d.sync_seen_hi = q.sync_seen_hi || c.ext_sync;
            if (q.tmr == CFG_LAST) begin
               d.cfg.dither = c.strap[STRAP_DITHER_BIT];
               d.cfg.hiccup = c.strap[STRAP_HICCUP_BIT];
               d.cfg.cur_limit = c.strap[STRAP_CLIMIT_BIT];
               d.cfg.thr_15 = c.strap[STRAP_THR15_BIT];
               d.cfg_valid = 1'b1;
               // Low throughout the window selects negative direction
               d.dir_pos = q.sync_seen_hi || c.ext_sync;
               d.tmr = '0;
               d.st = ST_SOFTSTART;
            end else begin
               d.tmr = q.tmr + 1'b1;
            end
         end
         ST_SOFTSTART: begin
            d.tmr = '0;
            if (halt_req) begin
               d.st = ST_HALT;
            end else if (c.ss_done) begin
               // Overload timing only starts once the ramp is done
               d.st = ST_ACTIVE;
            end
         end
         ST_ACTIVE: begin
            if (halt_req) begin
               d.st = ST_HALT;
               d.tmr = '0;
            end else if (q.cfg.hiccup && f.peak_oc) begin
               if (q.tmr == ON_LAST) begin
                  d.st = ST_HICCUP_OFF;
                  d.tmr = '0;
               end else begin
                  d.tmr = q.tmr + 1'b1;
               end
            end else begin
               // Without hiccup the limiter simply keeps clipping
               d.tmr = '0;
            end
         end
         ST_HICCUP_OFF: begin
            if (q.tmr == OFF_LAST) begin
               d.st = ST_SOFTSTART;
               d.tmr = '0;
            end else begin
               d.tmr = q.tmr + 1'b1;
            end
         end
         ST_HALT: begin
            d.tmr = '0;
            if (!halt_req) begin
               d.st = ST_SOFTSTART;
            end
         end
         default: begin
            d.st = ST_OFF;
            d.tmr = '0;
         end
      endcase

      // Strap may only be re-read after an enable or supply drop
      if (en_lost) begin
         d.st = ST_OFF;
         d.cfg_valid = 1'b0;
         d.tmr = '0;
      end

      running = (d.st == ST_SOFTSTART) || (d.st == ST_ACTIVE);

      // Current limit loop: slow stepping keeps the loop stable
      if (q.cfg.cur_limit && running) begin
         d.cl_div = q.cl_div + 1'b1;
         if (q.cl_div == CL_DIV_RST) begin
            if (c.aux_over_ref && (q.cl_level != 8'h00)) begin
               d.cl_level = q.cl_level - 8'h01;
            end else if (!c.aux_over_ref && (q.cl_level != CL_LEVEL_MAX)) begin
               d.cl_level = q.cl_level + 8'h01;
            end
         end
      end else begin
         d.cl_level = CL_LEVEL_MAX;
         d.cl_div = CL_DIV_RST;
      end

      d.sw_en = running && !f.vout_ov;
      d.float_sw = running && f.vout_ov;
      d.ss_dis = !running;
      d.forced_pwm_en = running && c.forced_pwm_req && !f.vin_ov;
      d.fwd_only = f.vin_ov;
      d.bst_sink = c.boot_ov;
      // Reported only; regulation is untouched
      d.fb_rep = fb_masked;
      d.pk_flag = f.peak_oc;
      d.fault = f.thermal || f.peak_oc || fb_masked || f.vout_ov ||
                f.vin_ov || pg_fault || f.boot_uv;
   end

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         q <= '0;
         q.st <= ST_OFF;
         q.cl_level <= CL_LEVEL_MAX;
         q.ss_dis <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign o_fault_flag_n_o = 1'b0;
   assign o_fault_flag_n_oe = q.fault;
   assign o_cfg = q.cfg;
   assign o_cfg_valid = q.cfg_valid;
   assign o_dir_positive = q.dir_pos;
   assign o_state = q.st;
   assign o_switch_en = q.sw_en;
   assign o_ss_discharge = q.ss_dis;
   assign o_float_switch_nodes = q.float_sw;
   assign o_forced_pwm_en = q.forced_pwm_en;
   assign o_forward_only = q.fwd_only;
   assign o_boot_clamp_sink = q.bst_sink;
   assign o_fb_ov_report = q.fb_rep;
   assign o_peak_overcurrent_trip = q.pk_flag;
   assign o_peak_limit_level = q.cl_level;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_nrst);

   AST_FLAG_SET: assert property (f.thermal |=> o_fault_flag_n_oe)
      else $error("fault pin not pulled on thermal fault");
   AST_FLAG_FREE: assert property (
      (f == '0) |=> !o_fault_flag_n_oe)
      else $error("fault pin held with no fault");
   AST_HICCUP_IN: assert property (
      (q.st == ST_ACTIVE) && q.cfg.hiccup && f.peak_oc && !halt_req &&
      !en_lost && (q.tmr == ON_LAST)
      |=> (q.st == ST_HICCUP_OFF) && o_ss_discharge && !o_switch_en)
      else $error("hiccup not entered after on-time");
   AST_HICCUP_OUT: assert property (
      (q.st == ST_HICCUP_OFF) && (q.tmr == OFF_LAST) && !en_lost
      |=> q.st == ST_SOFTSTART)
      else $error("no soft-start after hiccup off-time");
   AST_NO_HICCUP: assert property (
      (q.st == ST_ACTIVE) && !q.cfg.hiccup |=> q.st != ST_HICCUP_OFF)
      else $error("shutdown with hiccup disabled");
   AST_DIR_HOLD: assert property (
      (q.st == ST_ACTIVE) |-> $stable(q.dir_pos))
      else $error("direction changed after soft-start");
   AST_CFG_HOLD: assert property (
      q.cfg_valid && $past(q.cfg_valid) |-> $stable(q.cfg))
      else $error("strap setting changed while held");
   AST_FB_MASK: assert property (
      c.light_load || (q.st == ST_SOFTSTART) |=> !o_fb_ov_report)
      else $error("feedback guard reported while masked");
   AST_VIN_OV: assert property (
      f.vin_ov |=> !o_forced_pwm_en && o_forward_only)
      else $error("forced PWM kept during input overvoltage");
   AST_THERMAL: assert property (
      f.thermal && !en_lost && (q.st == ST_ACTIVE) |=> q.st == ST_HALT)
      else $error("thermal trip did not stop converter");
   AST_BOOT_SINK: assert property (
      c.boot_ov |=> o_boot_clamp_sink)
      else $error("boot clamp not sinking");
   AST_CL_DOWN: assert property (
      q.cfg.cur_limit && (q.st == ST_ACTIVE) && !halt_req && !en_lost &&
      !(q.cfg.hiccup && f.peak_oc && (q.tmr == ON_LAST)) &&
      c.aux_over_ref && (q.cl_div == CL_DIV_RST) && (q.cl_level != 8'h00)
      |=> o_peak_limit_level == $past(q.cl_level) - 8'h01)
      else $error("peak limit not lowered");
   AST_VOUT_STOP: assert property (
      f.vout_ov |=> !o_switch_en)
      else $error("power stage left on during output overvoltage");
   AST_VOUT_FLOAT: assert property (
      f.vout_ov && running |=> o_float_switch_nodes)
      else $error("switch nodes not floated during output overvoltage");
   AST_VOUT_RESUME: assert property (
      !f.vout_ov && running |=> o_switch_en && !o_float_switch_nodes)
      else $error("conversion not resumed after output overvoltage");
   AST_PG_FLAG: assert property (
      f.pg_low && (q.st == ST_ACTIVE) |=> o_fault_flag_n_oe)
      else $error("fault pin not pulled on power good loss");
   AST_PG_MASK: assert property (
      (q.st == ST_SOFTSTART) && !f.thermal && !f.peak_oc && !f.vout_ov &&
      !f.vin_ov && !f.boot_uv |=> !o_fault_flag_n_oe)
      else $error("power good or guard flagged during soft-start");
   AST_FB_REPORT: assert property (
      f.fb_ov && (q.st == ST_ACTIVE) && !c.light_load |=>
      o_fb_ov_report && o_fault_flag_n_oe)
      else $error("feedback overvoltage not reported");
   AST_PEAK_FLAG: assert property (
      f.peak_oc |=> o_peak_overcurrent_trip && o_fault_flag_n_oe)
      else $error("peak overcurrent not reported");
   AST_BOOT_UV: assert property (
      f.boot_uv && !en_lost &&
      ((q.st == ST_SOFTSTART) || (q.st == ST_ACTIVE)) |=> q.st == ST_HALT)
      else $error("boot undervoltage did not stop converter");
   AST_HALT_EXIT: assert property (
      (q.st == ST_HALT) && !halt_req && !en_lost |=> q.st == ST_SOFTSTART)
      else $error("no soft-start after thermal or boot recovery");
   AST_STRAP_READ: assert property (
      (q.st == ST_READ_CFG) && (q.tmr == CFG_LAST) && !en_lost |=>
      o_cfg_valid && (o_cfg.dither == $past(c.strap[STRAP_DITHER_BIT])) &&
      (o_cfg.thr_15 == $past(c.strap[STRAP_THR15_BIT])))
      else $error("strap setting not taken at end of read window");
   AST_EN_DROP: assert property (
      en_lost |=> (q.st == ST_OFF) && !o_cfg_valid && !o_switch_en)
      else $error("enable drop did not release the strap setting");

   COV_HICCUP: cover property (q.st == ST_ACTIVE ##1 q.st == ST_HICCUP_OFF);
   COV_HALT: cover property (q.st == ST_ACTIVE ##1 q.st == ST_HALT);
   COV_FLAG: cover property (!o_fault_flag_n_oe ##1 o_fault_flag_n_oe);
   COV_CL_STEP: cover property (
      q.cfg.cur_limit && (o_peak_limit_level != CL_LEVEL_MAX));

endmodule
`default_nettype wire

// ===== verif/cfsup_stage_model.sv
/*
 * Far side of the supervisor: soft-start ramp and the pulled-up fault
 * line seen by the host. Assumes the supervisor's registered outputs.
 */
`timescale 1ns/1ps
`default_nettype none
module cfsup_stage_model #(
   parameter int RAMP_CYC = 200
) (
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic i_switch_en,
   input wire logic i_ss_discharge,
   input wire logic i_flag_o,
   input wire logic i_flag_oe,
   output logic o_ss_done,
   output logic o_fault_pin
);
   int ramp_q;
   // Pull-up holds the line high whenever nobody sinks it
   assign o_fault_pin = i_flag_oe ? i_flag_o : 1'b1;
   // Ramp restarts from zero after every discharge
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         ramp_q <= 0;
      end else if (i_ss_discharge) begin
         ramp_q <= 0;
      end else if (i_switch_en && ramp_q < RAMP_CYC) begin
         ramp_q <= ramp_q + 1;
      end
   end
   assign o_ss_done = (ramp_q >= RAMP_CYC);
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
/*
 * Self-checking bench for the supervisor, all sixteen straps, random sync
 * level, shutdown kind and glitch widths from a fixed seed. Assumes the stage model beside it.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import cfsup_pkg::*;
   localparam int ON_CYC = 20;
   localparam int OFF_CYC = 40;
   logic i_clock, i_nrst, ss_done, pin, flag_o, flag_oe, cfg_valid;
   logic dir_pos, sw_en, ss_dis, float_sw, forced_pwm_en, fwd_only, clamp;
   logic fb_rep, oc_trip;
   logic [7:0] level;
   cfsup_fault_t flt;
   cfsup_ctrl_t ctl, ctl_dut;
   cfsup_cfg_t cfg;
   cfsup_state_t st;
   int bad_count, samples_checked, n, b;

   initial begin
      i_clock = 1'b0;
      forever #5 i_clock = ~i_clock;
   end
   always_comb begin
      ctl_dut = ctl;
      ctl_dut.ss_done = ss_done;
   end

   cfsup_top #(.HICCUP_ON_CYCLES(ON_CYC), .HICCUP_OFF_CYCLES(OFF_CYC)) dut (
      .i_clock(i_clock), .i_nrst(i_nrst), .i_fault(flt), .i_ctrl(ctl_dut),
      .o_fault_flag_n_o(flag_o), .o_fault_flag_n_oe(flag_oe),
      .o_cfg(cfg), .o_cfg_valid(cfg_valid), .o_dir_positive(dir_pos),
      .o_state(st), .o_switch_en(sw_en), .o_ss_discharge(ss_dis),
      .o_float_switch_nodes(float_sw), .o_forced_pwm_en(forced_pwm_en),
      .o_forward_only(fwd_only), .o_boot_clamp_sink(clamp),
      .o_fb_ov_report(fb_rep), .o_peak_overcurrent_trip(oc_trip),
      .o_peak_limit_level(level));
   cfsup_stage_model stage (
      .i_clock(i_clock), .i_nrst(i_nrst), .i_switch_en(sw_en),
      .i_ss_discharge(ss_dis), .i_flag_o(flag_o), .i_flag_oe(flag_oe),
      .o_ss_done(ss_done), .o_fault_pin(pin));

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic cfsup_cfg_t exp_cfg(input logic [3:0] s);
      return '{dither: s[0], hiccup: s[1], cur_limit: s[2], thr_15: s[3]};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         bad_count++;
      end
   endtask
   task automatic wait_state(input cfsup_state_t s, input int lim);
      #1;
      n = 0;
      while (st !== s && n < lim) begin
         @(posedge i_clock);
         #1;
         n++;
      end
      chk(st, s);
   endtask
   // Caller judges the pin; a wait may be meant to run out
   task automatic wait_pin(input logic lvl, input int lim);
      #1;
      n = 0;
      while (pin !== lvl && n < lim) begin
         @(posedge i_clock);
         #1;
         n++;
      end
   endtask
   task automatic start_up(input logic [3:0] s, input logic sy);
      @(posedge i_clock);
      ctl.strap <= s;
      ctl.ext_sync <= sy;
      ctl.en_high <= 1'b1;
      wait_state(ST_SOFTSTART, 40);
      chk(cfg, exp_cfg(s));
      chk(dir_pos, sy);
      chk(cfg_valid, 1'b1);
      @(posedge i_clock);
      ctl.strap <= ~s;
      ctl.ext_sync <= ~sy;
      wait_state(ST_ACTIVE, 260);
      chk(cfg, exp_cfg(s));
      chk(dir_pos, sy);
      chk(level, 8'hFF);
   endtask
   task automatic shut_down(input logic uv);
      @(posedge i_clock);
      if (uv) ctl.vcc_uv <= 1'b1;
      else ctl.en_high <= 1'b0;
      wait_state(ST_OFF, 10);
      chk(cfg_valid, 1'b0);
      @(posedge i_clock);
      ctl.vcc_uv <= 1'b0;
      ctl.en_high <= 1'b0;
   endtask
   task automatic fault_effects(input int k);
      case (k)
         0: chk(st, ST_HALT);
         2: begin
            chk(forced_pwm_en, 1'b0);
            chk(fwd_only, 1'b1);
         end
         3: begin
            chk(float_sw, 1'b1);
            chk(sw_en, 1'b0);
         end
         4: begin
            chk(fb_rep, 1'b1);
            chk(sw_en, 1'b1);
         end
         5: begin
            chk(oc_trip, 1'b1);
            chk(st, ST_ACTIVE);
         end
         6: begin
            chk(st, ST_HALT);
            chk(sw_en, 1'b0);
         end
         default: chk(st, ST_ACTIVE);
      endcase
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // ****************************************************************
   // Tests
   // ****************************************************************
   initial begin
      repeat (40000) @(posedge i_clock);
      bad_count++;
      report_and_stop();
   end
   initial begin
      void'($urandom(64837));
      i_nrst = 1'b0;
      flt = '0;
      ctl = '0;
      bad_count = 0;
      samples_checked = 0;
      repeat (2) @(posedge i_clock);
      i_nrst <= 1'b1;
      #1;
      chk(st, ST_OFF);
      chk(ss_dis, 1'b1);
      chk(level, 8'hFF);
      chk(flag_oe, 1'b0);
      for (int s = 0; s < 16; s++) begin
         start_up(4'(s), 1'($urandom));
         shut_down(1'($urandom));
      end
      $display("done strap decode");
      start_up(4'h0, 1'b0);
      @(posedge i_clock);
      ctl.forced_pwm_req <= 1'b1;
      for (b = 0; b < 7; b++) begin
         @(posedge i_clock);
         flt[b] <= 1'b1;
         repeat (20 + $urandom % 70) @(posedge i_clock);
         flt[b] <= 1'b0;
         wait_pin(1'b0, 110);
         chk(pin, 1'b1);
         @(posedge i_clock);
         flt[b] <= 1'b1;
         wait_pin(1'b0, 100);
         chk(pin, 1'b0);
         repeat (30) @(posedge i_clock);
         #1;
         fault_effects(b);
         @(posedge i_clock);
         flt[b] <= 1'b0;
         wait_pin(1'b1, 100);
         chk(pin, 1'b1);
         wait_state(ST_ACTIVE, 300);
         chk(float_sw, 1'b0);
         chk(forced_pwm_en, 1'b1);
      end
      @(posedge i_clock);
      ctl.light_load <= 1'b1;
      flt.fb_ov <= 1'b1;
      wait_pin(1'b0, 120);
      chk(pin, 1'b1);
      chk(fb_rep, 1'b0);
      flt.fb_ov <= 1'b0;
      repeat (110) @(posedge i_clock);
      ctl.light_load <= 1'b0;
      shut_down(1'b0);
      @(posedge i_clock);
      flt.pg_low <= 1'b1;
      flt.fb_ov <= 1'b1;
      ctl.en_high <= 1'b1;
      wait_state(ST_SOFTSTART, 40);
      wait_pin(1'b0, 150);
      chk(pin, 1'b1);
      wait_state(ST_ACTIVE, 100);
      wait_pin(1'b0, 3);
      chk(pin, 1'b0);
      @(posedge i_clock);
      flt <= '0;
      wait_pin(1'b1, 100);
      chk(pin, 1'b1);
      $display("done fault pin");
      shut_down(1'b0);
      start_up(4'h2, 1'b1);
      @(posedge i_clock);
      flt.peak_oc <= 1'b1;
      ctl.aux_over_ref <= 1'b1;
      wait_state(ST_HICCUP_OFF, 130);
      chk(sw_en, 1'b0);
      chk(ss_dis, 1'b1);
      wait_state(ST_SOFTSTART, 60);
      chk(n >= OFF_CYC - 2 && n <= OFF_CYC + 2, 1'b1);
      wait_state(ST_ACTIVE, 260);
      wait_state(ST_HICCUP_OFF, ON_CYC + 5);
      chk(n >= ON_CYC - 1 && n <= ON_CYC + 2, 1'b1);
      @(posedge i_clock);
      flt.peak_oc <= 1'b0;
      ctl.aux_over_ref <= 1'b0;
      wait_state(ST_ACTIVE, 400);
      chk(level, 8'hFF);
      $display("done hiccup");
      shut_down(1'b1);
      start_up(4'h4, 1'b0);
      @(posedge i_clock);
      ctl.aux_over_ref <= 1'b1;
      repeat (100) @(posedge i_clock);
      #1;
      chk(level < 8'hFF && level > 8'hF0, 1'b1);
      ctl.aux_over_ref <= 1'b0;
      repeat (200) @(posedge i_clock);
      #1;
      chk(level, 8'hFF);
      ctl.boot_ov <= 1'b1;
      repeat (5) @(posedge i_clock);
      #1;
      chk(clamp, 1'b1);
      ctl.boot_ov <= 1'b0;
      repeat (5) @(posedge i_clock);
      #1;
      chk(clamp, 1'b0);
      $display("done limit and clamp");
      report_and_stop();
   end
endmodule
`default_nettype wire
